// ---- rtl/codec_config_registers.sv ----
// What this block does
// - decode addresses two through six
// - conversion clock is divided clock over divider
// - divider resets to decimal eighteen
// - divided clock is master over twice first divider
// - signed phase byte shifts sampling instant
// - phase byte resets to zero
// - gain register holds three two-bit fields
// - monitor gain: squelch, 0, -8, -18 dB
// - monitor gain resets to squelch
// - input gain resets to 0 dB
// - output gain resets to 0 dB
// - input select picks loopback, main, aux, sum
// - input select resets to main inputs
// - filter bit resets 0, 1 bypasses
// - analog read repeats low nibble high
// - soft power-down clears after pin cycles
// - 16-bit mode ignores primary control bits
// - digital register resets to zero
`timescale 1ns/1ps
`include "codec_config_params.svh"

module codec_config_registers (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic cmdValid,
  input wire codec_config_pkg::cmd_word_t cmdWord,
  input wire logic [7:0] clockDivider,
  input wire logic powerDownPin,
  input wire logic [1:0] primaryCtrlIn,
  output logic [15:0] readData,
  output logic readValid,
  output logic fclkTick,
  output logic convTick,
  output logic sampleTick,
  output logic [7:0] conversionDivider,
  output logic [7:0] samplePhaseShift,
  output codec_config_pkg::gain_fields_t gainFields,
  output logic [1:0] inputSelect,
  output logic highPassBypass,
  output logic frameSyncOutDisable,
  output logic [7:0] digitalConfig,
  output logic powerDown,
  output logic [1:0] primaryCtrl,
  output logic softResetPulse
);
  import codec_config_pkg::*;

  cfg_state_t cur_ff;
  cfg_state_t nxt_cur;

  // =====================================================
  // decode helpers
  function automatic logic hitReg(input cmd_word_t w,
                                  input logic [4:0] a);
    hitReg = (w.addr == a);
  endfunction : hitReg

  function automatic cfg_state_t defaults();
    cfg_state_t d;
    d = '0;
    d.convDiv = `RST_CONV_DIV;
    d.phase = `RST_PHASE;
    d.gain = `RST_GAIN;
    d.analog = `RST_ANALOG;
    d.digital = `RST_DIGITAL;
    d.pdState = PD_EXTERNAL;
    d.powerDown = 1'b0;
    defaults = d;
  endfunction : defaults

  logic wrStrobe;
  logic rdStrobe;
  logic [8:0] fclkLimit;
  logic [8:0] sampleLoad;

  always_comb begin
    wrStrobe = cmdValid && !cmdWord.rw;
    rdStrobe = cmdValid && cmdWord.rw;
    fclkLimit = {clockDivider, 1'b0};
    // base delay keeps negative shifts reachable
    sampleLoad = 9'(`SAMPLE_BASE_DELAY +
                 {{1{cur_ff.phase[7]}}, cur_ff.phase});
  end

  // =====================================================
  // next state
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.readValid = 1'b0;
    nxt_cur.softResetPulse = 1'b0;
    nxt_cur.fclkTick = 1'b0;
    nxt_cur.convTick = 1'b0;
    nxt_cur.sampleTick = 1'b0;

    // divided clock from master clock
    if (fclkLimit <= 9'h001 || cur_ff.fclkCnt >= fclkLimit - 9'h001) begin
      nxt_cur.fclkCnt = '0;
      nxt_cur.fclkTick = 1'b1;
    end else begin
      nxt_cur.fclkCnt = cur_ff.fclkCnt + 9'h001;
    end

    // conversion clock from divided clock
    if (cur_ff.fclkTick) begin
      if (cur_ff.convDiv <= 8'h01 ||
          cur_ff.convCnt >= cur_ff.convDiv - 8'h01) begin
        nxt_cur.convCnt = '0;
        nxt_cur.convTick = 1'b1;
      end else begin
        nxt_cur.convCnt = cur_ff.convCnt + 8'h01;
      end
    end

    // sampling instant, master clock resolution
    if (cur_ff.convTick) begin
      nxt_cur.sampleCnt = sampleLoad;
      nxt_cur.sampleBusy = 1'b1;
    end else if (cur_ff.sampleBusy) begin
      if (cur_ff.sampleCnt == 9'h000) begin
        nxt_cur.sampleBusy = 1'b0;
        nxt_cur.sampleTick = 1'b1;
      end else begin
        nxt_cur.sampleCnt = cur_ff.sampleCnt - 9'h001;
      end
    end

    // power-down pin cycle tracking
    case (cur_ff.pdState)
      PD_EXTERNAL: begin
        if (cur_ff.digital[`DIG_SWPD_BIT]) begin
          nxt_cur.pdState = PD_WAIT_LOW;
        end
      end
      PD_WAIT_LOW: begin
        if (!powerDownPin) begin
          nxt_cur.pdState = PD_WAIT_HIGH;
        end
      end
      PD_WAIT_HIGH: begin
        if (powerDownPin) begin
          nxt_cur.pdState = PD_EXTERNAL;
          nxt_cur.digital[`DIG_SWPD_BIT] = 1'b0;
        end
      end
      default: begin
        nxt_cur.pdState = PD_EXTERNAL;
      end
    endcase

    // register writes; a write setting the bit wins
    if (wrStrobe) begin
      if (hitReg(cmdWord, `ADDR_CONV_DIV)) begin
        nxt_cur.convDiv = cmdWord.data;
      end
      if (hitReg(cmdWord, `ADDR_PHASE)) begin
        nxt_cur.phase = cmdWord.data;
      end
      if (hitReg(cmdWord, `ADDR_GAIN)) begin
        nxt_cur.gain = cmdWord.data[5:0];
      end
      if (hitReg(cmdWord, `ADDR_ANALOG)) begin
        nxt_cur.analog = cmdWord.data[3:0];
      end
      if (hitReg(cmdWord, `ADDR_DIGITAL)) begin
        nxt_cur.digital = cmdWord.data;
        nxt_cur.digital[`DIG_SWRST_BIT] = 1'b0;
        if (cmdWord.data[`DIG_SWPD_BIT]) begin
          nxt_cur.pdState = PD_WAIT_LOW;
        end
        nxt_cur.rstPending = cmdWord.data[`DIG_SWRST_BIT];
      end
    end

    // read back, upper byte always zero
    if (rdStrobe) begin
      nxt_cur.readValid = 1'b1;
      case (cmdWord.addr)
        `ADDR_CONV_DIV: nxt_cur.readData = {8'h00, cur_ff.convDiv};
        `ADDR_PHASE: nxt_cur.readData = {8'h00, cur_ff.phase};
        `ADDR_GAIN: nxt_cur.readData = {10'h000, cur_ff.gain};
        `ADDR_ANALOG: begin
          nxt_cur.readData = {8'h00, cur_ff.analog,
                              cur_ff.analog};
        end
        `ADDR_DIGITAL: nxt_cur.readData = {8'h00, cur_ff.digital};
        default: nxt_cur.readData = 16'h0000;
      endcase
    end else if (cmdValid) begin
      nxt_cur.readData = 16'h0000;
    end

    // outputs derived from settled state
    nxt_cur.powerDown = nxt_cur.digital[`DIG_SWPD_BIT] ||
                        !powerDownPin;
    nxt_cur.primaryCtrl = nxt_cur.digital[`DIG_MODE16_BIT] ?
                          2'b00 : primaryCtrlIn;

    // soft reset takes one cycle after the write
    if (cur_ff.rstPending) begin
      nxt_cur = defaults();
      nxt_cur.powerDown = !powerDownPin;
      nxt_cur.primaryCtrl = primaryCtrlIn;
      nxt_cur.softResetPulse = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_ff <= defaults();
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // =====================================================
  // outputs straight from state flops
  assign readData = cur_ff.readData;
  assign readValid = cur_ff.readValid;
  assign fclkTick = cur_ff.fclkTick;
  assign convTick = cur_ff.convTick;
  assign sampleTick = cur_ff.sampleTick;
  assign conversionDivider = cur_ff.convDiv;
  assign samplePhaseShift = cur_ff.phase;
  assign gainFields = cur_ff.gain;
  assign inputSelect = cur_ff.analog[1:0];
  assign highPassBypass = cur_ff.analog[`ANA_HPF_BIT];
  assign frameSyncOutDisable = cur_ff.digital[`DIG_FSD_OFF_BIT];
  assign digitalConfig = cur_ff.digital;
  assign powerDown = cur_ff.powerDown;
  assign primaryCtrl = cur_ff.primaryCtrl;
  assign softResetPulse = cur_ff.softResetPulse;

endmodule : codec_config_registers

// ---- rtl/codec_config_params.svh ----
`ifndef CODEC_CONFIG_PARAMS_SVH
`define CODEC_CONFIG_PARAMS_SVH

// =====================================================
// command word layout
`define CMD_CTRL_HI 15
`define CMD_CTRL_LO 14
`define CMD_RW_BIT 13
`define CMD_ADDR_HI 12
`define CMD_ADDR_LO 8
`define CMD_DATA_HI 7
`define CMD_DATA_LO 0

// =====================================================
// register addresses
`define ADDR_CONV_DIV 5'h02
`define ADDR_PHASE 5'h03
`define ADDR_GAIN 5'h04
`define ADDR_ANALOG 5'h05
`define ADDR_DIGITAL 5'h06

// =====================================================
// reset values
`define RST_CONV_DIV 8'h12
`define RST_PHASE 8'h00
`define RST_GAIN 6'h05
`define RST_ANALOG 4'h1
`define RST_DIGITAL 8'h00

// =====================================================
// field positions
`define GAIN_MON_LO 4
`define GAIN_IN_LO 2
`define GAIN_OUT_LO 0
`define ANA_SEL_LO 0
`define ANA_HPF_BIT 2
`define DIG_SWPD_BIT 0
`define DIG_SWRST_BIT 1
`define DIG_MODE16_BIT 2
`define DIG_FSD_OFF_BIT 3

// =====================================================
// timing
`define SAMPLE_BASE_DELAY 9'h080

`endif

// ---- rtl/codec_config_pkg.sv ----
package codec_config_pkg;

  typedef struct packed {
    logic [1:0] ctrl;
    logic rw;
    logic [4:0] addr;
    logic [7:0] data;
  } cmd_word_t;

  typedef struct packed {
    logic [1:0] monitorGain;
    logic [1:0] inputGain;
    logic [1:0] outputGain;
  } gain_fields_t;

  typedef enum logic [1:0] {
    PD_EXTERNAL,
    PD_WAIT_LOW,
    PD_WAIT_HIGH
  } pd_state_t;

  typedef struct packed {
    logic [7:0] convDiv;
    logic [7:0] phase;
    gain_fields_t gain;
    logic [3:0] analog;
    logic [7:0] digital;
    pd_state_t pdState;
    logic rstPending;
    logic softResetPulse;
    logic [8:0] fclkCnt;
    logic fclkTick;
    logic [7:0] convCnt;
    logic convTick;
    logic [8:0] sampleCnt;
    logic sampleBusy;
    logic sampleTick;
    logic [15:0] readData;
    logic readValid;
    logic powerDown;
    logic [1:0] primaryCtrl;
  } cfg_state_t;

endpackage : codec_config_pkg

// ---- testbench/codec_config_registers_chk.sv ----
`timescale 1ns/1ps
// ==========
// port checks
module codec_config_registers_chk (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic cmdValid,
  input wire codec_config_pkg::cmd_word_t cmdWord,
  input wire logic readValid,
  input wire logic [15:0] readData,
  input wire logic [7:0] conversionDivider,
  input wire codec_config_pkg::gain_fields_t gainFields,
  input wire logic [7:0] digitalConfig,
  input wire logic powerDown,
  input wire logic powerDownPin,
  input wire logic [1:0] primaryCtrl
);
  import codec_config_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic wr_ff;
  logic swrst_ff;
  assign wr_ff = cmdValid && !cmdWord.rw;
  // remembers a soft reset write for one cycle so a gain write in the next cycle is not judged
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n) swrst_ff <= 1'b0;
    else swrst_ff <= wr_ff && cmdWord.addr == 5'h06 && cmdWord.data[1];
  a_read_answer: assert property (
    cmdValid && cmdWord.rw |=> readValid) else $error("no read answer");
  a_no_answer: assert property (
    !(cmdValid && cmdWord.rw) |=> !readValid) else $error("stray answer");
  a_gain_store: assert property (
    wr_ff && cmdWord.addr == 5'h04 && !swrst_ff
    |=> gainFields == $past(cmdWord.data[5:0])) else $error("gain lost");
  a_analog_mirror: assert property (
    cmdValid && cmdWord.rw && cmdWord.addr == 5'h05
    |=> readData[7:4] == readData[3:0]) else $error("no mirror");
  a_mode_mask: assert property (
    digitalConfig[2] && $past(digitalConfig[2]) |-> primaryCtrl == 2'h0)
    else $error("ctrl not masked");
  a_pd_pin: assert property (
    $past(reset_n) && ($past(!powerDownPin) || digitalConfig[0]
    && $past(digitalConfig[0])) |-> powerDown) else $error("no power down");
  a_srst_bit: assert property (
    digitalConfig[1] == 1'b0) else $error("reset bit stuck");
  a_srst_restore: assert property (
    swrst_ff |=> conversionDivider == 8'h12 && gainFields == 6'h05
    && digitalConfig == 8'h00) else $error("defaults not restored");
endmodule : codec_config_registers_chk
bind codec_config_registers codec_config_registers_chk u_chk (.*);

// ---- testbench/host_model.sv ----
`timescale 1ns/1ps
// ==========
// host side
module host_model (
  input wire logic ref_clk,
  output codec_config_pkg::cmd_word_t cmdWord,
  output logic cmdValid,
  input wire logic [15:0] readData
);
  import codec_config_pkg::*;
  logic [15:0] lastRead;
  initial begin
    cmdValid = 1'b0;
    cmdWord = '0;
  end
  task automatic xfer(input logic rw, input logic [4:0] a,
    input logic [7:0] d);
    cmdWord <= '{2'b00, rw, a, d};
    cmdValid <= 1'b1;
    @(posedge ref_clk);
    cmdValid <= 1'b0;
    // released word must not look valid
    cmdWord <= ~cmdWord;
    @(posedge ref_clk);
    // read data already stands from the previous edge
    lastRead = readData;
  endtask : xfer
endmodule : host_model

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
// ==========
// bench
module tb_top;
  import codec_config_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic powerDownPin = 1'b1;
  logic [7:0] clockDivider = 8'h02;
  logic [1:0] primaryCtrlIn = 2'h2;
  logic cmdValid, readValid, fclkTick, convTick, sampleTick;
  logic highPassBypass, frameSyncOutDisable, powerDown, softResetPulse;
  cmd_word_t cmdWord;
  logic [15:0] readData;
  logic [7:0] conversionDivider, samplePhaseShift, digitalConfig;
  gain_fields_t gainFields;
  logic [1:0] inputSelect, primaryCtrl;
  int n_fail = 0;
  int check_count = 0;
  always #4 ref_clk = ~ref_clk;
  codec_config_registers u_codec_config_registers (.*);
  host_model u_host_model (.*);
  task automatic chk(input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    u_host_model.xfer(1'b0, a, d);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    u_host_model.xfer(1'b1, a, 8'h00);
    chk(u_host_model.lastRead, exp);
  endtask : rd
  task automatic t_defaults;
    rd(5'h02, 16'h0012);
    rd(5'h03, 16'h0000);
    rd(5'h04, 16'h0005);
    rd(5'h05, 16'h0011);
    rd(5'h06, 16'h0000);
    rd(5'h07, 16'h0000);
    $display("t_defaults done");
  endtask : t_defaults
  task automatic t_fields;
    for (int k = 0; k < 4; k++) begin
      wr(5'h04, {2'h3, k[1:0], k[1:0], k[1:0]});
      chk({10'h0, gainFields}, {10'h0, k[1:0], k[1:0], k[1:0]});
      wr(5'h05, {6'h3D, k[1:0]});
      rd(5'h05, {8'h0, 2'h1, k[1:0], 2'h1, k[1:0]});
      chk({13'h0, highPassBypass, inputSelect}, {13'h1, k[1:0]});
    end
    $display("t_fields done");
  endtask : t_fields
  task automatic t_digital;
    wr(5'h06, 8'h0C);
    @(posedge ref_clk);
    chk({14'h0, primaryCtrl}, 16'h0000);
    chk({15'h0, frameSyncOutDisable}, 16'h0001);
    wr(5'h06, 8'h00);
    @(posedge ref_clk);
    chk({14'h0, primaryCtrl}, 16'h0002);
    wr(5'h02, 8'hA5);
    wr(5'h06, 8'h02);
    @(posedge ref_clk);
    chk({15'h0, softResetPulse}, 16'h0001);
    chk({8'h0, digitalConfig}, 16'h0000);
    @(posedge ref_clk);
    rd(5'h02, 16'h0012);
    wr(5'h06, 8'h01);
    chk({15'h0, powerDown}, 16'h0001);
    @(posedge ref_clk) powerDownPin <= 1'b0;
    @(posedge ref_clk) powerDownPin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk({7'h0, digitalConfig, powerDown}, 16'h0000);
    $display("t_digital done");
  endtask : t_digital
  task automatic t_timing;
    int nf, nc;
    wr(5'h02, 8'h02);
    // let the conversion counter settle onto the new short period first
    repeat (40) @(posedge ref_clk);
    nf = 0;
    nc = 0;
    repeat (80) begin
      @(posedge ref_clk);
      nf += int'(fclkTick === 1'b1);
      nc += int'(convTick === 1'b1);
    end
    chk(16'(nf), 16'h0014);
    chk(16'(nc), 16'h000A);
    // long period so the full phase range fits
    clockDivider <= 8'h64;
    for (int i = 0; i < 2; i++) begin
      wr(5'h03, i ? 8'hF8 : 8'h00);
      chk({8'h0, samplePhaseShift}, i ? 16'h00F8 : 16'h0000);
      do @(posedge ref_clk); while (convTick !== 1'b1);
      nf = 0;
      do begin
        @(posedge ref_clk);
        nf++;
      end while (sampleTick !== 1'b1);
      chk(16'(nf), i ? 16'h007A : 16'h0082);
    end
    $display("t_timing done");
  endtask : t_timing
  task automatic close_out;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  initial begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    t_defaults();
    t_fields();
    t_digital();
    t_timing();
    close_out();
  end
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
endmodule : tb_top
